// ===== pkg/sop_array_pkg.sv
// Shared constants for the sum-of-products logic array: array geometry,
// register map, macrocell configuration bit positions and erased values.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package sop_array_pkg;
    // Array geometry
    localparam int NUM_DED      = 10;
    localparam int NUM_MC       = 8;
    localparam int NUM_LINES    = 36;
    localparam int NUM_TERMS    = 74;
    localparam int TERMS_PER_MC = 8;
    localparam int ROW_OE_BASE  = 64;
    localparam int ROW_PRESET   = 72;
    localparam int ROW_CLEAR    = 73;
    localparam int ROW_AW       = 7;

    // Register map (byte addresses)
    localparam logic [11:0] ADDR_CFG    = 12'h000;
    localparam logic [11:0] ADDR_CMD    = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [1:0]  ARRAY_SEL   = 2'h1;    // Address bits 11:10 for array window

    // Command bits
    localparam int CMD_ERASE_BIT  = 0;
    localparam int CMD_SECURE_BIT = 1;

    // Status fields
    localparam int ST_SECURE_BIT = 0;
    localparam int ST_Q_LSB      = 8;
    localparam int ST_PIN_LSB    = 16;
    localparam int ST_OE_LSB     = 24;

    // Macrocell configuration nibble: bit positions of A, B, C, D
    localparam int CFG_W       = 4;
    localparam int CFG_POL_BIT = 0;  // A: 1 = active low
    localparam int CFG_REG_BIT = 1;  // B: 1 = registered output
    localparam int CFG_C_BIT   = 2;  // C
    localparam int CFG_D_BIT   = 3;  // D

    // Erased state of the configuration cells
    localparam logic [31:0] CFG_ERASED = 32'hFFFF_FFFF;

    // Bus answer timing: cycles from request to data-ready phase, minus one
    localparam logic [1:0] RD_LAT = 2'h1;
endpackage : sop_array_pkg

// ===== core/sop_cell_array.sv
// Nonvolatile crossing cells of the AND plane, held as flip-flops.
// All cells are visible in parallel for evaluation; readback is registered.
// Assumes the caller refuses writes when the design is secured.
`timescale 1ns/1ps
module sop_cell_array #(
    parameter int ROWS = 74,
    parameter int COLS = 36,
    parameter int RAW  = 7
) (
    // Clock and reset
    input  wire logic                 sys_clk_in,
    input  wire logic                 rst_in,
    // Write side
    input  wire logic                 erase_in,
    input  wire logic                 wr_en_in,
    input  wire logic [RAW-1:0]       wr_row_in,
    input  wire logic                 wr_word_in,
    input  wire logic [31:0]          wr_data_in,
    input  wire logic [31:0]          wr_mask_in,
    // Read side
    input  wire logic [RAW-1:0]       rd_row_in,
    input  wire logic                 rd_word_in,
    output logic      [31:0]          rd_data_out,
    // Parallel cell view
    output logic      [ROWS*COLS-1:0] cells_out
);
    typedef struct packed {
        logic [ROWS-1:0][COLS-1:0] cells;
        logic [31:0]               rd_data;
    } mem_state_t;

    mem_state_t st_reg;
    mem_state_t st_next;

    // Rows wider than two bus words or more rows than the row address can reach are refused
    if (COLS <= 32 || COLS > 64 || ROWS > (1 << RAW)) begin : g_bad_size
        $error("sop_cell_array: unsupported ROWS/COLS");
    end

    // Read-modify-write through a 64-bit view of the addressed row
    always_comb begin
        logic [63:0] wide;
        logic [63:0] rwide;
        wide    = 64'h0;
        rwide   = 64'h0;
        st_next = st_reg;
        if (int'(rd_row_in) < ROWS)
            rwide[COLS-1:0] = st_reg.cells[rd_row_in];
        st_next.rd_data = rd_word_in ? rwide[63:32] : rwide[31:0];
        if (erase_in) begin
            st_next.cells = '0;                                 // [R6]
        end else if (wr_en_in && int'(wr_row_in) < ROWS) begin
            wide[COLS-1:0] = st_reg.cells[wr_row_in];
            if (wr_word_in)
                wide[63:32] = (wide[63:32] & ~wr_mask_in) | (wr_data_in & wr_mask_in);
            else
                wide[31:0] = (wide[31:0] & ~wr_mask_in) | (wr_data_in & wr_mask_in);
            st_next.cells[wr_row_in] = wide[COLS-1:0];
        end
    end

    // Reset leaves the array in the erased state
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign rd_data_out = st_reg.rd_data;
    assign cells_out   = st_reg.cells;
endmodule : sop_cell_array

// ===== core/sop_logic_array.sv
// Programmable AND plane with fixed OR plane and eight I/O macrocells,
// programmed and read back over an Avalon-MM slave with waitrequest.
// Assumes pins and the logic clock pin are asynchronous to sys_clk_in.
`timescale 1ns/1ps

// Summary of operation
// R1: AND plane sees 36 lines: true/inverted of 10 inputs and 8 feedbacks.
// R2: 74 terms: 8x8 sum terms, 8 enables, one preset, one clear.
// R3: Each term ANDs the lines whose crossing cell is connected.
// R4: A term tied to both polarities of one signal is always false.
// R5: A term with no connections is always true; enable then drives permanently.
// R6: Bulk erase opens every crossing connection.
// R7: Programmer connects every crossing of unused terms to keep them false.
// R8: Eight macrocells, each with flip-flop, two muxes, four configuration bits.
// R9: Pin gets OR result or flip-flop output as configured.
// R10: Flip-flop captures OR result on each rising logic clock edge.
// R11: Preset term sets all flip-flops high at the next rising clock edge.
// R12: Clear term forces all flip-flops low without waiting for a clock edge.
// R13: Clear wins over preset when both are true.
// R14: Each macrocell may invert its selected output.
// R15: Pin driver enabled while its enable term is true, else released.
// R16: Feedback comes from pin, flip-flop or OR result.
// R17: OR-result feedback works for either output type and with driver off.
// R18: Flip-flop feedback works even with combinatorial output.
// R19: Pin feedback serves input and bidirectional use, also with registered output.
// R20: Once secured, readback and programming are refused until bulk erase.
// R21: Programmer sets security after programming, in or after that cycle.
// R22: All flip-flops share one clock; preset and clear act on all together.
// R23: Configuration bit meanings are held as named package constants.
module sop_logic_array #(
    parameter int NUM_DED = sop_array_pkg::NUM_DED,
    parameter int NUM_MC  = sop_array_pkg::NUM_MC
) (
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    // Avalon-MM slave
    input  wire logic [11:0] address_in,
    input  wire logic        read_in,
    input  wire logic        write_in,
    input  wire logic [31:0] writedata_in,
    input  wire logic [3:0]  byteenable_in,
    output logic      [31:0] readdata_out,
    output logic             waitrequest_out,
    // Logic pins
    input  wire logic        logic_clk_in,
    input  wire logic [9:0]  ded_pin_in,
    input  wire logic [7:0]  io_pin_in,
    output logic      [7:0]  io_pin_out,
    output logic      [7:0]  io_pin_oe_out
);
    localparam int LINES = sop_array_pkg::NUM_LINES;
    localparam int TERMS = sop_array_pkg::NUM_TERMS;
    localparam int RAW   = sop_array_pkg::ROW_AW;
    localparam int TPM   = sop_array_pkg::TERMS_PER_MC;

    // Pin widths are fixed by the port list, so other counts cannot be served
    if (NUM_DED != sop_array_pkg::NUM_DED || NUM_MC != sop_array_pkg::NUM_MC
        || 2 * (NUM_DED + NUM_MC) != LINES) begin : g_bad_pins
        $error("sop_logic_array: pin counts must match the 36-line plane");
    end

    typedef struct packed {
        logic [9:0]  ded_s1;
        logic [9:0]  ded_s2;
        logic [7:0]  io_s1;
        logic [7:0]  io_s2;
        logic        lclk_s1;
        logic        lclk_s2;
        logic        lclk_s3;
        logic [7:0]  q;
        logic [7:0]  orr;
        logic [7:0]  pin_out;
        logic [7:0]  pin_oe;
        logic [31:0] cfg;
        logic        secure;
        logic        wait_n;
        logic [1:0]  cnt;
        logic [31:0] rdata;
    } state_t;

    state_t st_reg;
    state_t st_next;

    // Cell array connections
    logic [TERMS*LINES-1:0] cells;
    logic [31:0]            arr_rdata;
    logic                   arr_erase;
    logic                   arr_wr;
    logic                   arr_hit;
    logic [RAW-1:0]         arr_row;
    logic                   arr_word;

    // Combinational plane values
    logic [LINES-1:0] lines;
    logic [TERMS-1:0] pterm;
    logic [7:0]       or_now;
    logic             preset_t;
    logic             clear_t;
    logic             lclk_rise;
    logic             req;
    logic             bus_done;

    // One product term: every connected line must be high
    function automatic logic eval_term(input logic [LINES-1:0] conn,
                                       input logic [LINES-1:0] lv);
        eval_term = &(~conn | lv);                                 // [R3] [R4] [R5]
    endfunction : eval_term

    // Configuration nibble of one macrocell
    function automatic logic [3:0] mc_cfg(input logic [31:0] cfg, input int m);
        mc_cfg = cfg[m*sop_array_pkg::CFG_W +: sop_array_pkg::CFG_W];
    endfunction : mc_cfg

    // Byte enables widened to a bit mask
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction : be_mask

    sop_cell_array #(
        .ROWS (TERMS),
        .COLS (LINES),
        .RAW  (RAW)
    ) u_cells (
        .sys_clk_in  (sys_clk_in),
        .rst_in      (rst_in),
        .erase_in    (arr_erase),
        .wr_en_in    (arr_wr),
        .wr_row_in   (arr_row),
        .wr_word_in  (arr_word),
        .wr_data_in  (writedata_in),
        .wr_mask_in  (be_mask(byteenable_in)),
        .rd_row_in   (arr_row),
        .rd_word_in  (arr_word),
        .rd_data_out (arr_rdata),
        .cells_out   (cells)
    );

    // Array window decode: two words per row, 74 rows valid
    assign arr_hit  = (address_in[11:10] == sop_array_pkg::ARRAY_SEL)
                      && (int'(address_in[9:3]) < TERMS);
    assign arr_row  = address_in[9:3];
    assign arr_word = address_in[2];
    assign req      = read_in || write_in;
    assign bus_done = write_in && !st_reg.wait_n;

    // Bus writes take effect on the edge that also shows waitrequest low
    assign arr_erase = bus_done && (address_in[11:2] == sop_array_pkg::ADDR_CMD[11:2])
                       && byteenable_in[0] && writedata_in[sop_array_pkg::CMD_ERASE_BIT];
    assign arr_wr    = bus_done && arr_hit && !st_reg.secure;      // [R20]

    // Input lines built from synchronised pins and registered feedback;
    // feedback uses last cycle's OR result so the plane never forms a loop
    always_comb begin
        logic [3:0] c;
        logic       fb;
        c     = 4'h0;
        fb    = 1'b0;
        lines = '0;
        for (int k = 0; k < NUM_DED; k++) begin
            lines[2*k]   = st_reg.ded_s2[k];                       // [R1]
            lines[2*k+1] = ~st_reg.ded_s2[k];
        end
        for (int m = 0; m < NUM_MC; m++) begin
            c = mc_cfg(st_reg.cfg, m);
            if (c[sop_array_pkg::CFG_C_BIT] && c[sop_array_pkg::CFG_D_BIT])
                fb = st_reg.io_s2[m];                              // [R16] [R19]
            else if (c[sop_array_pkg::CFG_C_BIT])
                fb = st_reg.orr[m];                                // [R17]
            else
                fb = st_reg.q[m];                                  // [R18]
            lines[2*(NUM_DED+m)]   = fb;                           // [R1]
            lines[2*(NUM_DED+m)+1] = ~fb;
        end
    end

    // Evaluate all product terms and the fixed OR plane
    always_comb begin
        pterm  = '0;
        or_now = '0;
        for (int t = 0; t < TERMS; t++)
            pterm[t] = eval_term(cells[t*LINES +: LINES], lines);  // [R2] [R3]
        for (int m = 0; m < NUM_MC; m++)
            or_now[m] = |pterm[m*TPM +: TPM];                      // [R2]
    end

    assign preset_t  = pterm[sop_array_pkg::ROW_PRESET];
    assign clear_t   = pterm[sop_array_pkg::ROW_CLEAR];
    assign lclk_rise = st_reg.lclk_s2 && !st_reg.lclk_s3;

    // Next-state logic: synchronisers, macrocells, bus slave
    always_comb begin
        logic [3:0] c;
        logic       sel;
        c       = 4'h0;
        sel     = 1'b0;
        st_next = st_reg;

        // Two-flop synchronisers; the logic clock edge is seen on stage two
        st_next.ded_s1  = ded_pin_in;
        st_next.ded_s2  = st_reg.ded_s1;
        st_next.io_s1   = io_pin_in;
        st_next.io_s2   = st_reg.io_s1;
        st_next.lclk_s1 = logic_clk_in;
        st_next.lclk_s2 = st_reg.lclk_s1;
        st_next.lclk_s3 = st_reg.lclk_s2;

        // Shared flip-flop control: clear acts every cycle, preset on the edge
        st_next.orr = or_now;
        if (clear_t)
            st_next.q = 8'h00;                                     // [R12] [R13] [R22]
        else if (lclk_rise && preset_t)
            st_next.q = 8'hFF;                                     // [R11] [R22]
        else if (lclk_rise)
            st_next.q = or_now;                                    // [R10]

        // Output select, polarity and enable per macrocell
        for (int m = 0; m < NUM_MC; m++) begin
            c   = mc_cfg(st_reg.cfg, m);                           // [R8] [R23]
            sel = c[sop_array_pkg::CFG_REG_BIT] ? st_reg.q[m] : st_reg.orr[m];  // [R9]
            st_next.pin_out[m] = c[sop_array_pkg::CFG_POL_BIT] ? ~sel : sel;    // [R14]
            st_next.pin_oe[m]  = pterm[sop_array_pkg::ROW_OE_BASE + m];         // [R15] [R5]
        end

        // Bus handshake: count one cycle, then latch read data and drop wait on the same edge
        if (req && st_reg.wait_n) begin
            st_next.cnt = st_reg.cnt + 2'h1;
            if (st_reg.cnt == sop_array_pkg::RD_LAT)
                st_next.wait_n = 1'b0;
        end else begin
            st_next.cnt    = 2'h0;
            st_next.wait_n = 1'b1;
        end

        if (read_in && st_reg.wait_n && st_reg.cnt == sop_array_pkg::RD_LAT) begin
            st_next.rdata = 32'h0;
            if (arr_hit)
                st_next.rdata = st_reg.secure ? 32'h0 : arr_rdata; // [R20]
            else if (address_in[11:2] == sop_array_pkg::ADDR_CFG[11:2])
                st_next.rdata = st_reg.secure ? 32'h0 : st_reg.cfg;  // [R20]
            else if (address_in[11:2] == sop_array_pkg::ADDR_STATUS[11:2]) begin
                st_next.rdata[sop_array_pkg::ST_SECURE_BIT] = st_reg.secure;
                st_next.rdata[sop_array_pkg::ST_Q_LSB +: 8]   = st_reg.q;
                st_next.rdata[sop_array_pkg::ST_PIN_LSB +: 8] = st_reg.io_s2;
                st_next.rdata[sop_array_pkg::ST_OE_LSB +: 8]  = st_reg.pin_oe;
            end
        end

        // Register writes; erase also clears the lock and restores the erased configuration
        if (bus_done) begin
            if (address_in[11:2] == sop_array_pkg::ADDR_CFG[11:2] && !st_reg.secure)
                st_next.cfg = (st_reg.cfg & ~be_mask(byteenable_in))
                              | (writedata_in & be_mask(byteenable_in));  // [R8] [R20]
            if (address_in[11:2] == sop_array_pkg::ADDR_CMD[11:2] && byteenable_in[0]) begin
                if (writedata_in[sop_array_pkg::CMD_ERASE_BIT]) begin
                    st_next.cfg    = sop_array_pkg::CFG_ERASED;     // [R6]
                    st_next.secure = 1'b0;                          // [R20]
                end else if (writedata_in[sop_array_pkg::CMD_SECURE_BIT]) begin
                    st_next.secure = 1'b1;                          // [R20] [R21]
                end
            end
        end
    end

    // State register; reset restores the erased, unlocked condition
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg        <= '0;
            st_reg.cfg    <= sop_array_pkg::CFG_ERASED;
            st_reg.wait_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign readdata_out    = st_reg.rdata;
    assign waitrequest_out = st_reg.wait_n;
    assign io_pin_out      = st_reg.pin_out;
    assign io_pin_oe_out   = st_reg.pin_oe;
endmodule : sop_logic_array

// ===== sim/sop_logic_array_chk.sv
// Bus-side checker for the logic array: answer timing, read data hold,
// blank answers for command, unmapped and secured reads.
// Assumes it is bound to the array top and sees its Avalon-MM ports only.
`timescale 1ns/1ps
module sop_logic_array_chk (
    // Clock and reset
    input wire logic        sys_clk_in,
    input wire logic        rst_in,
    // Avalon-MM slave
    input wire logic [11:0] address_in,
    input wire logic        read_in,
    input wire logic        write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0]  byteenable_in,
    input wire logic [31:0] readdata_out,
    input wire logic        waitrequest_out
);
    logic       sec_reg;
    logic       ans;
    logic [9:0] wa;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    // Word address and answer strobe
    assign ans = !waitrequest_out;
    assign wa  = address_in[11:2];
    // Secure state as software sees it; erase wins over set
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sec_reg <= 1'b0;
        end else if (write_in && ans && wa == sop_array_pkg::ADDR_CMD[11:2]
                     && byteenable_in[0]) begin
            sec_reg <= writedata_in[0] ? 1'b0 : (writedata_in[1] | sec_reg);
        end
    end
    sequence s_start;
        $rose(read_in || write_in);
    endsequence
    sequence s_answer;
        waitrequest_out ##1 waitrequest_out ##1 !waitrequest_out;
    endsequence
    a_wait_fixed: assert property (s_start |-> s_answer)
        else $error("answer not two edges after request");
    a_wait_single: assert property (ans |=> waitrequest_out)
        else $error("waitrequest low longer than one cycle");
    a_ans_req: assert property (ans |-> (read_in || write_in))
        else $error("answer without a request");
    a_rd_hold: assert property (!$stable(readdata_out) |-> (read_in && ans))
        else $error("read data moved outside a read answer");
    a_cmd_zero: assert property ((read_in && ans && wa == 10'h001) |-> readdata_out == 32'h0)
        else $error("command read not zero");
    a_unmapped_zero: assert property ((read_in && ans && wa[9:8] == 2'h0 && wa > 10'h002)
        |-> readdata_out == 32'h0) else $error("unmapped read not zero");
    a_secure_blank: assert property (
        (read_in && ans && sec_reg && (wa[9:8] == 2'h1 || wa == 10'h000))
        |-> readdata_out == 32'h0) else $error("secured read not blank");
    a_status_sec: assert property (
        (read_in && ans && wa == 10'h002) |-> readdata_out[0] == sec_reg)
        else $error("status secure flag wrong");
endmodule : sop_logic_array_chk

bind sop_logic_array sop_logic_array_chk u_chk (.sys_clk_in, .rst_in, .address_in, .read_in,
    .write_in, .writedata_in, .byteenable_in, .readdata_out, .waitrequest_out);

// ===== sim/board_model.sv
// Board around the logic array: makes logic clock pulses on request and
// resolves the I/O wires between the array drivers and board sources.
// Assumes the bench requests a pulse no more than once per 8 cycles.
`timescale 1ns/1ps
module board_model (
    // Clock and pulse request
    input wire logic        sys_clk_in,
    input wire logic        step_in,
    // Pin side
    input wire logic [7:0]  pin_val_in,
    input wire logic [7:0]  pin_oe_in,
    input wire logic [7:0]  ext_val_in,
    output logic            logic_clk_out,
    output logic     [7:0]  pin_level_out
);
    logic [3:0] cnt_reg = 4'h0;
    // Four cycles high then four low, so the synchroniser sees each level
    always @(posedge sys_clk_in) begin
        cnt_reg <= step_in ? 4'h8 : (cnt_reg != 4'h0 ? cnt_reg - 4'h1 : 4'h0);
    end
    assign logic_clk_out = cnt_reg > 4'h4;
    // Array driver wins while enabled, else the board source shows
    assign pin_level_out = (pin_val_in & pin_oe_in) | (ext_val_in & ~pin_oe_in);
endmodule : board_model

// ===== sim/sop_logic_array_test.sv
// Self-checking bench for the logic array: programs terms and macrocell
// modes over the bus and watches pins, register path and security.
// Assumes the board model supplies logic clock pulses and wire levels.
`timescale 1ns/1ps
module sop_logic_array_test;
    logic        clk  = 1'b0;
    logic        rst  = 1'b1;
    logic [11:0] addr = 12'h000;
    logic        rd   = 1'b0;
    logic        wr   = 1'b0;
    logic [31:0] wd   = 32'h0;
    logic [3:0]  be   = 4'hF;
    logic [9:0]  ded  = 10'h000;
    logic [7:0]  ext  = 8'h00;
    logic        step = 1'b0;
    logic [31:0] rdata;
    logic        wreq;
    logic        lclk;
    logic [7:0]  lvl;
    logic [7:0]  pout;
    logic [7:0]  poe;
    int          fails  = 0;
    int          checks = 0;
    int          cyc    = 0;
    // Clock and cycle ceiling against hangs
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            $display("wrong value at %0t: run too long", $time);
            print_verdict();
        end
    end
    sop_logic_array u_dut (.sys_clk_in(clk), .rst_in(rst), .address_in(addr), .read_in(rd),
        .write_in(wr), .writedata_in(wd), .byteenable_in(be), .readdata_out(rdata),
        .waitrequest_out(wreq), .logic_clk_in(lclk), .ded_pin_in(ded), .io_pin_in(lvl),
        .io_pin_out(pout), .io_pin_oe_out(poe));
    board_model u_board (.sys_clk_in(clk), .step_in(step), .pin_val_in(pout),
        .pin_oe_in(poe), .ext_val_in(ext), .logic_clk_out(lclk), .pin_level_out(lvl));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk
    // One bus cycle; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        rd   <= !w;
        wr   <= w;
        wd   <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0);
        chk(n <= 50, 1, "bus answer late");
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wreg
    task automatic rreg(input logic [11:0] a, input logic [31:0] e, input string m);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e, m);
    endtask : rreg
    task automatic status(output logic [31:0] q);
        bus(1'b0, sop_array_pkg::ADDR_STATUS, 32'h0, q);
    endtask : status
    task automatic row(input int r, input logic [31:0] lo);
        wreg(12'h400 + 12'(8 * r), lo);
    endtask : row
    task automatic settle();
        repeat (10) @(posedge clk);
    endtask : settle
    task automatic tick();
        step <= 1'b1;
        @(posedge clk);
        step <= 1'b0;
        repeat (14) @(posedge clk);
    endtask : tick
    task automatic t_program();
        for (int r = 1; r < 8; r++) row(r, 32'h3);
        row(0, 32'h1);
        row(64, 32'h40);
        row(72, 32'h3);
        row(73, 32'h3);
        rreg(12'h400, 32'h1, "row readback");
    endtask : t_program
    task automatic t_comb();
        ded[3] <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            wreg(sop_array_pkg::ADDR_CFG, 32'hFFFF_FFF4 | p);
            for (int v = 0; v < 2; v++) begin
                ded[0] <= v[0];
                settle();
                chk(pout[0], v[0] ^ p[0], "combinatorial out");
            end
        end
        ded[3] <= 1'b0;
        settle();
        chk(poe[0], 0, "enable term false");
    endtask : t_comb
    task automatic t_reg();
        logic [31:0] st;
        wreg(sop_array_pkg::ADDR_CFG, 32'hFFFF_FFF6);
        ded[0] <= 1'b1;
        tick();
        chk(pout[0], 1, "registered load");
        ded[0] <= 1'b0;
        settle();
        chk(pout[0], 1, "holds without clock");
        tick();
        chk(pout[0], 0, "registered load low");
        row(72, 32'h10);
        ded[2] <= 1'b1;
        settle();
        chk(pout[0], 0, "preset before edge");
        tick();
        status(st);
        chk(st[15:8], 32'hFF, "preset all cells");
        row(73, 32'h4);
        ded[1] <= 1'b1;
        settle();
        status(st);
        chk(st[15:8], 32'h0, "clear without edge");
        tick();
        status(st);
        chk(st[15:8], 32'h0, "clear beats preset");
        ded[2:1] <= 2'h0;
    endtask : t_reg
    task automatic t_pin_fb();
        wreg(sop_array_pkg::ADDR_CFG, 32'hFFFF_FFFC);
        row(0, 32'h0010_0000);
        for (int v = 0; v < 2; v++) begin
            ext[0] <= v[0];
            settle();
            chk(pout[0], v[0], "pin feedback");
        end
        wreg(sop_array_pkg::ADDR_CFG, 32'hFFFF_FFFE);
        tick();
        chk(pout[0], 1, "pin feedback registered");
    endtask : t_pin_fb
    // Pin released and low, so only register or OR feedback can keep the output high
    task automatic t_fb_paths();
        wreg(sop_array_pkg::ADDR_CFG, 32'hFFFF_FFF0);
        ext[0] <= 1'b0;
        settle();
        chk(pout[0], 1, "register feedback");
        ded[1] <= 1'b1;
        settle();
        chk(pout[0], 0, "register feedback cleared");
        ded[1] <= 1'b0;
        wreg(sop_array_pkg::ADDR_CFG, 32'hFFFF_FFF4);
        row(1, 32'h1);
        ded[0] <= 1'b1;
        settle();
        chk(pout[0], 1, "or feedback set");
        ded[0] <= 1'b0;
        settle();
        chk(pout[0], 1, "or feedback holds with driver off");
    endtask : t_fb_paths
    task automatic t_secure();
        logic [31:0] st;
        wreg(sop_array_pkg::ADDR_CMD, 32'h2);
        status(st);
        chk(st[0], 1, "secure flag");
        rreg(12'h400, 32'h0, "secured array read");
        rreg(sop_array_pkg::ADDR_CFG, 32'h0, "secured cfg read");
        wreg(sop_array_pkg::ADDR_CFG, 32'hFFFF_FFF5);
        settle();
        chk(pout[0], 1, "secured cfg write");
        wreg(sop_array_pkg::ADDR_CMD, 32'h1);
        rreg(sop_array_pkg::ADDR_CFG, sop_array_pkg::CFG_ERASED, "erased cfg");
        rreg(12'h400, 32'h0, "erased row");
    endtask : t_secure
    task automatic print_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        chk(wreq, 1, "wait idle in reset");
        chk(poe, 0, "enables in reset");
        rst <= 1'b0;
        settle();
        chk(poe, 32'hFF, "erased terms true");
        rreg(sop_array_pkg::ADDR_CFG, sop_array_pkg::CFG_ERASED, "cfg reset");
        rreg(12'h00C, 32'h0, "unmapped read");
        rreg(sop_array_pkg::ADDR_CMD, 32'h0, "command read");
        t_program();
        t_comb();
        t_reg();
        t_pin_fb();
        t_fb_paths();
        t_secure();
        print_verdict();
    end
endmodule : sop_logic_array_test
